// ### core/fsh_ctrl.sv
// Run-control interlock: hold knob, external start/pause, feeder alarm, offsets
// Notes on behaviour
// - Knob acts only in automatic mode, ignored in any other mode.
// - Knob enable bit set: position read from knob inputs a and b.
// - Knob enable bit clear: knob ignored, its pins left to other uses.
// - Position 1 permits spindle rotation and carriage movement.
// - Position 2 permits spindle, inhibits all carriage movement.
// - Position 3 inhibits spindle, permits carriage movement.
// - Before running, manual spindle keys work at 1 and 2; no start at 3.
// - Single block at 2: spindle commands run, moves wait for position 1.
// - Single block at 3: no block runs until knob at 2 or 1.
// - Continuous, 1 to 2: carriage pauses, spindle state kept.
// - Continuous, 2 to 3 stops spindle; 3 to 2 restores saved state.
// - Continuous, 2 to 1 resumes paused carriage motion.
// - Escape or reset during hold: initial state, saved state discarded.
// - External start/pause enabled by bit, and only in automatic mode.
// - External start/pause are active low, act as panel keys.
// - Start or pause held on entry to automatic raises abnormality alarm.
// - Cycle end command checks feeder alarm; asserted stops and alarms.
// - Program end commands skip the feeder alarm check.
// - Cycle stop on: halt after cycle end command and show it.
// - Inside canned cycles single stop applies after each step.
// - Current offset edit waits for tool change; others apply now.
// - Without tool change, offset applies at end, reset or interruption.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "fsh_params.svh"
module fsh_ctrl
   import fsh_pkg::*;
#(
   parameter int unsigned DEB_CYC = `FSH_DEB_CYC
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Machine pins; knob and start/pause active low, feeder alarm active high
   input  wire logic        hold_knob_input_a_n,
   input  wire logic        hold_knob_input_b_n,
   input  wire logic        ext_cycle_start_in_n,
   input  wire logic        ext_pause_in_n,
   input  wire logic [7:0]  feeder_alarm_in,
   // Mode levels, and panel keys as one-cycle pulses
   input  wire logic        mode_auto,
   input  wire logic        single_mode,
   input  wire logic        key_start,
   input  wire logic        key_pause,
   input  wire logic        key_esc,
   input  wire logic        key_spin_on,
   input  wire logic        key_spin_off,
   // Program events as one-cycle pulses; in_canned and tool_offset_num as levels
   input  wire logic        prog_spin_on,
   input  wire logic        prog_spin_off,
   input  wire logic        block_done,
   input  wire logic        in_canned,
   input  wire logic        canned_step_done,
   input  wire logic        cycle_end_command,
   input  wire logic        program_end_command,
   input  wire logic        tool_change,
   input  wire logic [3:0]  tool_offset_num,
   // Permits and indications
   output logic             spindle_run,
   output logic             move_permit,
   output logic             block_permit,
   output logic             discard_motion,
   output logic             cycle_stop_shown,
   output logic [15:0]      active_offset
);

   localparam int CW = `FSH_CNT_W;
   // Last count value before a steady input is accepted
   localparam logic [CW-1:0] DEB_LAST = CW'(DEB_CYC - 1);

   fsh_state_t s_r;
   fsh_state_t s_nxt;

   logic [`FSH_NIN-1:0] raw;
   logic [`FSH_NIN-1:0] deb_rise;
   logic [2:0]          psel_f;
   logic                wr;
   logic                rd;
   logic                knob_on;
   logic                ext_on;
   logic                ext_st;
   logic                ext_ps;
   logic                start;
   logic                pause;
   logic                halt;
   fsh_pos_t            pos_now;

   //-----------------------------------------------------------
   // Input capture
   //-----------------------------------------------------------
   assign psel_f = s_r.ctrl[`FSH_C_PSEL_LO +: 3];
   // All inputs turned active high before the synchroniser
   assign raw[0] = ~hold_knob_input_a_n;
   assign raw[1] = ~hold_knob_input_b_n;
   assign raw[2] = ~ext_cycle_start_in_n;
   assign raw[3] = ~ext_pause_in_n;
   // Feeder alarm is taken from the pin that software selects
   assign raw[4] = feeder_alarm_in[psel_f];

   //-----------------------------------------------------------
   // Debounce edges
   //-----------------------------------------------------------
   // High in the cycle before a debounced input rises, so a held
   // external button acts once, as a single press of the panel key
   always_comb begin
      deb_rise = '0;
      for (int i = 0; i < `FSH_NIN; i++) begin
         deb_rise[i] = s_r.sy2[i] & ~s_r.deb[i] & (s_r.cnt[i] == DEB_LAST);
      end
   end

   //-----------------------------------------------------------
   // Qualification
   //-----------------------------------------------------------
   assign knob_on = s_r.ctrl[`FSH_C_KNOB] & mode_auto;
   assign ext_on  = s_r.ctrl[`FSH_C_EXT] & mode_auto;
   assign ext_st  = ext_on & deb_rise[2];
   assign ext_ps  = ext_on & deb_rise[3];
   assign start   = key_start | ext_st;
   assign pause   = key_pause | ext_ps;
   // Single stop after a block, or after each step of a canned cycle
   assign halt    = single_mode & (block_done | (in_canned & canned_step_done));
   assign wr      = psel & penable & pwrite;
   assign rd      = psel & ~pwrite;

   always_comb begin
      pos_now = POS1;
      if (knob_on) begin
         if (s_r.deb[1]) begin
            pos_now = POS3;
         end else if (s_r.deb[0]) begin
            pos_now = POS2;
         end
      end
   end

   //-----------------------------------------------------------
   // Next state
   //-----------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.sy1 = raw;
      s_nxt.sy2 = s_r.sy1;
      for (int i = 0; i < `FSH_NIN; i++) begin
         // Count restarts whenever the input falls back to the debounced level
         if (s_r.sy2[i] == s_r.deb[i]) begin
            s_nxt.cnt[i] = '0;
         end else if (s_r.cnt[i] == DEB_LAST) begin
            s_nxt.deb[i] = s_r.sy2[i];
            s_nxt.cnt[i] = '0;
         end else begin
            s_nxt.cnt[i] = s_r.cnt[i] + 1'b1;
         end
      end
      s_nxt.pos     = pos_now;
      s_nxt.auto_d  = mode_auto;
      s_nxt.discard = 1'b0;

      //--------------------------------------------------------
      // Run state
      //--------------------------------------------------------
      // Feeder alarm is looked at only on the cycle end command
      unique case (s_r.st)
         ST_IDLE, ST_PAUSE, ST_SSTOP, ST_CSTOP: begin
            if (start) begin
               s_nxt.st        = ST_RUN;
               s_nxt.cstop_ind = 1'b0;
            end
         end
         ST_RUN: begin
            if (pause) begin
               s_nxt.st = ST_PAUSE;
            end else if (cycle_end_command && s_r.deb[4]) begin
               s_nxt.st  = ST_ALARM;
               s_nxt.fdr = 1'b1;
            end else if (cycle_end_command && s_r.ctrl[`FSH_C_CSTOP]) begin
               s_nxt.st        = ST_CSTOP;
               s_nxt.cstop_ind = 1'b1;
            end else if (program_end_command) begin
               s_nxt.st = ST_IDLE;
            end else if (halt) begin
               s_nxt.st = ST_SSTOP;
            end
         end
         ST_ALARM: begin
         end
         default: begin
            s_nxt.st = ST_IDLE;
         end
      endcase
      // Leaving automatic mode drops any run or alarm state
      if (!mode_auto) begin
         s_nxt.st = ST_IDLE;
      end
      if (key_esc) begin
         s_nxt.st        = ST_IDLE;
         s_nxt.spin      = 1'b0;
         s_nxt.discard   = (s_r.st != ST_IDLE);
         s_nxt.cstop_ind = 1'b0;
      end

      //--------------------------------------------------------
      // Spindle request: held through position 3 and restored after it
      //--------------------------------------------------------
      // Manual keys act only before the program runs
      if (s_r.st == ST_IDLE && key_spin_on && pos_now != POS3) begin
         s_nxt.spin = 1'b1;
      end
      if (s_r.st == ST_IDLE && key_spin_off) begin
         s_nxt.spin = 1'b0;
      end
      if (s_r.blk_o && prog_spin_on) begin
         s_nxt.spin = 1'b1;
      end
      if (s_r.blk_o && prog_spin_off) begin
         s_nxt.spin = 1'b0;
      end
      if (key_esc) begin
         s_nxt.spin = 1'b0;
      end

      //--------------------------------------------------------
      // Permits
      //--------------------------------------------------------
      // Single block at position 3 runs no block at all
      s_nxt.spin_o = s_nxt.spin & (pos_now != POS3);
      s_nxt.blk_o  = (s_nxt.st == ST_RUN) & ~(single_mode & pos_now == POS3);
      s_nxt.move_o = s_nxt.blk_o & (pos_now != POS2);

      //--------------------------------------------------------
      // Abnormality on entry to automatic
      //--------------------------------------------------------
      if (mode_auto && !s_r.auto_d && s_r.ctrl[`FSH_C_EXT] && (s_r.deb[2] || s_r.deb[3])) begin
         s_nxt.abn = 1'b1;
         s_nxt.st  = ST_ALARM;
      end

      //--------------------------------------------------------
      // Tool offsets
      //--------------------------------------------------------
      // A tool change brings in the entry of the new number at once
      if (tool_change) begin
         s_nxt.cur = tool_offset_num;
         s_nxt.act = s_r.tab[tool_offset_num];
      end else if (cycle_end_command || program_end_command || key_esc
                   || (s_r.st == ST_RUN && pause)) begin
         s_nxt.act = s_r.tab[s_r.cur];
      end

      //--------------------------------------------------------
      // APB access
      //--------------------------------------------------------
      // Read data and error flag load in setup and stand through access
      s_nxt.pslverr = 1'b0;
      if (psel && !penable) begin
         s_nxt.prdata  = '0;
         s_nxt.pslverr = (paddr != `FSH_A_CTRL) && (paddr != `FSH_A_STAT)
                         && (paddr != `FSH_A_OFS);
         if (rd) begin
            unique case (paddr)
               `FSH_A_CTRL: s_nxt.prdata = {25'h0, s_r.ctrl};
               `FSH_A_STAT: begin
                  s_nxt.prdata[2:0]       = s_r.st;
                  s_nxt.prdata[4:3]       = s_r.pos;
                  s_nxt.prdata[5]         = s_r.spin_o;
                  s_nxt.prdata[6]         = s_r.move_o;
                  s_nxt.prdata[7]         = s_r.blk_o;
                  s_nxt.prdata[8]         = s_r.cstop_ind;
                  s_nxt.prdata[`FSH_S_ABN] = s_r.abn;
                  s_nxt.prdata[`FSH_S_FDR] = s_r.fdr;
                  // Edited current offset not yet in force
                  s_nxt.prdata[11]        = (s_r.tab[s_r.cur] != s_r.act);
               end
               `FSH_A_OFS:  s_nxt.prdata = {s_r.act, 12'h0, s_r.cur};
               default:     s_nxt.prdata = 32'h0;
            endcase
         end
      end
      if (wr && !s_r.pslverr) begin
         unique case (paddr)
            `FSH_A_CTRL: s_nxt.ctrl = pwdata[6:0];
            `FSH_A_STAT: begin
               // Write one clears an alarm; a new alarm in the same cycle wins only if its flag was clear
               if (pwdata[`FSH_S_ABN] && s_nxt.abn == s_r.abn) begin
                  s_nxt.abn = 1'b0;
               end
               if (pwdata[`FSH_S_FDR] && s_nxt.fdr == s_r.fdr) begin
                  s_nxt.fdr = 1'b0;
               end
               if (s_nxt.st == ST_ALARM && !s_nxt.abn && !s_nxt.fdr) begin
                  s_nxt.st = ST_IDLE;
               end
            end
            `FSH_A_OFS: s_nxt.tab[pwdata[3:0]] = pwdata[31:16];
            default: begin
            end
         endcase
      end
   end

   //-----------------------------------------------------------
   // State register
   //-----------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         // Fields not listed below clear to zero
         s_r        <= '0;
         s_r.st     <= ST_IDLE;
         s_r.pos    <= POS1;
         s_r.ctrl   <= 7'(`FSH_CTRL_RST);
      end else begin
         s_r <= s_nxt;
      end
   end

   //-----------------------------------------------------------
   // Outputs
   //-----------------------------------------------------------
   assign prdata           = s_r.prdata;
   assign pslverr          = s_r.pslverr & psel & penable;
   // Every access completes in its first access cycle
   assign pready           = 1'b1;
   assign spindle_run      = s_r.spin_o;
   assign move_permit      = s_r.move_o;
   assign block_permit     = s_r.blk_o;
   assign discard_motion   = s_r.discard;
   assign cycle_stop_shown = s_r.cstop_ind;
   assign active_offset    = s_r.act;

endmodule : fsh_ctrl
`default_nettype wire

// ### core/fsh_params.svh
// Constants of the feed/spindle hold control block
`ifndef FSH_PARAMS_SVH
`define FSH_PARAMS_SVH
`define FSH_CLK_HZ     20000000
`define FSH_DEB_US     1000
`define FSH_DEB_CYC    ((`FSH_DEB_US * `FSH_CLK_HZ) / 1000000)
`define FSH_CNT_W      15
`define FSH_NIN        5
`define FSH_NOFS       16
`define FSH_OFS_W      16
`define FSH_A_CTRL     8'h00
`define FSH_A_STAT     8'h04
`define FSH_A_OFS      8'h08
`define FSH_C_KNOB     0
`define FSH_C_EXT      1
`define FSH_C_CSTOP    2
`define FSH_C_PSEL_LO  4
`define FSH_S_ABN      9
`define FSH_S_FDR      10
`define FSH_CTRL_RST   32'h0000_0000
`endif

// ### core/fsh_pkg.sv
// Types of the feed/spindle hold control block
`default_nettype none
`include "fsh_params.svh"
package fsh_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_PAUSE, ST_SSTOP, ST_CSTOP, ST_ALARM} fsh_st_t;
   typedef enum logic [1:0] {POS1, POS2, POS3} fsh_pos_t;
   typedef struct packed {
      logic [`FSH_NIN-1:0]                  sy1;
      logic [`FSH_NIN-1:0]                  sy2;
      logic [`FSH_NIN-1:0]                  deb;
      logic [`FSH_NIN-1:0][`FSH_CNT_W-1:0] cnt;
      fsh_st_t                              st;
      fsh_pos_t                             pos;
      logic                                 auto_d;
      logic [6:0]                           ctrl;
      logic                                 cstop_ind;
      logic                                 abn;
      logic                                 fdr;
      logic                                 spin;
      logic                                 spin_o;
      logic                                 move_o;
      logic                                 blk_o;
      logic                                 discard;
      logic [3:0]                           cur;
      logic [`FSH_OFS_W-1:0]                act;
      logic [`FSH_NOFS-1:0][`FSH_OFS_W-1:0] tab;
      logic [31:0]                          prdata;
      logic                                 pslverr;
   } fsh_state_t;
endpackage : fsh_pkg
`default_nettype wire

// ### testbench/fsh_ctrl_properties.sv
// Port-level concurrent checks of the run-control interlock
`timescale 1ns/1ps
`default_nettype none
module fsh_ctrl_properties
   import fsh_pkg::*;
#(
   parameter int unsigned DEB_CYC = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Mode and events
   input wire logic mode_auto,
   input wire logic key_start,
   input wire logic key_pause,
   input wire logic key_esc,
   input wire logic program_end_command,
   // Permits and indications
   input wire logic spindle_run,
   input wire logic move_permit,
   input wire logic block_permit,
   input wire logic discard_motion,
   input wire logic cycle_stop_shown
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence s_run_esc;
      key_esc && block_permit;
   endsequence
   sequence s_disc_pulse;
      discard_motion ##1 !discard_motion;
   endsequence

   property p_auto_only;  !mode_auto |=> !move_permit; endproperty
   property p_pause;      key_pause && move_permit |=> !move_permit; endproperty
   property p_move_blk;   move_permit |-> block_permit; endproperty
   property p_cstop_clr;  cycle_stop_shown && key_start |=> !cycle_stop_shown; endproperty
   property p_cstop_set;  $rose(cycle_stop_shown) |-> !move_permit; endproperty
   property p_pend;       program_end_command |=> !move_permit; endproperty
   property p_esc_off;    key_esc |=> !spindle_run && !move_permit; endproperty
   property p_esc_disc;   s_run_esc |=> s_disc_pulse; endproperty
   property p_disc_src;   discard_motion |-> $past(key_esc); endproperty

   a_auto_only: assert property (p_auto_only) else $error("move permit outside auto");
   a_pause: assert property (p_pause) else $error("pause left motion on");
   a_move_blk: assert property (p_move_blk) else $error("move without block permit");
   a_cstop_clr: assert property (p_cstop_clr) else $error("cycle stop not cleared");
   a_cstop_set: assert property (p_cstop_set) else $error("cycle stop while moving");
   a_pend: assert property (p_pend) else $error("program end kept motion");
   a_esc_off: assert property (p_esc_off) else $error("escape kept spindle or motion");
   a_esc_disc: assert property (p_esc_disc) else $error("no discard pulse");
   a_disc_src: assert property (p_disc_src) else $error("discard without escape");
endmodule : fsh_ctrl_properties

bind fsh_ctrl fsh_ctrl_properties #(.DEB_CYC(DEB_CYC)) fsh_ctrl_properties_i (.clk, .arst_n,
   .mode_auto, .key_start, .key_pause, .key_esc, .program_end_command, .spindle_run,
   .move_permit, .block_permit, .discard_motion, .cycle_stop_shown);
`default_nettype wire

// ### testbench/fsh_panel_model.sv
// Machine-side model: hold knob contacts and external start/pause lines
`timescale 1ns/1ps
`default_nettype none
module fsh_panel_model (
   // Clock
   input  wire logic       clk,
   // Commands from the bench
   input  wire logic [1:0] pos,
   input  wire logic       start,
   input  wire logic       pause,
   // Contact lines, pulled high when open
   output logic            a_n,
   output logic            b_n,
   output logic            st_n,
   output logic            sp_n
);
   initial {a_n, b_n, st_n, sp_n} = 4'hf;
   always @(posedge clk) begin
      a_n  <= pos != 2'd2;
      b_n  <= pos != 2'd3;
      st_n <= !start;
      sp_n <= !pause;
   end
endmodule : fsh_panel_model
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench of the run-control interlock
`timescale 1ns/1ps
`default_nettype none
`include "fsh_params.svh"
module tb_top;
   localparam int DEB = 4;
   logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, er, mode_auto, single_mode;
   logic        a_n, b_n, st_n, sp_n, st, sp, spin_o, move_o, blk_o, disc, cst, cnd;
   logic [7:0]  paddr, fdr;
   logic [31:0] pwdata, prdata, rd;
   logic [11:0] ev;
   logic [15:0] act, v, v2;
   logic [3:0]  tn;
   logic [1:0]  pos;
   int          error_cnt, comparisons, run, spin, sel;
   int          sel_tab[4] = '{2, 3, 2, 1};

   fsh_ctrl #(.DEB_CYC(DEB)) fsh_ctrl_i (.clk, .arst_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .hold_knob_input_a_n(a_n), .hold_knob_input_b_n(b_n),
      .ext_cycle_start_in_n(st_n), .ext_pause_in_n(sp_n), .feeder_alarm_in(fdr), .mode_auto,
      .single_mode, .key_start(ev[0]), .key_pause(ev[1]), .key_esc(ev[2]), .key_spin_on(ev[3]),
      .key_spin_off(ev[4]), .prog_spin_on(ev[9]), .prog_spin_off(ev[10]), .block_done(ev[8]),
      .in_canned(cnd), .canned_step_done(ev[11]), .cycle_end_command(ev[5]),
      .program_end_command(ev[6]), .tool_change(ev[7]), .tool_offset_num(tn),
      .spindle_run(spin_o), .move_permit(move_o), .block_permit(blk_o),
      .discard_motion(disc), .cycle_stop_shown(cst), .active_offset(act));
   fsh_panel_model fsh_panel_model_i (.clk, .pos, .start(st), .pause(sp), .a_n, .b_n, .st_n,
      .sp_n);

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      comparisons++;
      if (s !== x) begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, s, x);
      end
   endtask : chk

   task automatic results;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic rdy;
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      // Answer is taken as it stands ahead of the rising edge
      do begin
         @(negedge clk);
         {rdy, er, rd} = {pready, pslverr, prdata};
         @(posedge clk);
      end while (rdy !== 1'b1);
      {psel, penable} <= 2'b00;
   endtask : apb

   task automatic pulse(input int i);
      @(posedge clk);
      ev <= 12'h1 << i;
      @(posedge clk);
      ev <= '0;
   endtask : pulse

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle

   task automatic setpos(input int p);
      @(posedge clk);
      pos <= p[1:0];
      settle(DEB + 6);
   endtask : setpos

   // Bench model of the permits
   task automatic cmp;
      chk(move_o, 32'(run != 0 && !(single_mode && pos == 3) && pos != 2));
      chk(spin_o, 32'(spin != 0 && pos != 3));
      chk(blk_o, 32'(run != 0 && !(single_mode && pos == 3)));
   endtask : cmp

   initial begin
      {arst_n, psel, penable, pwrite, mode_auto, single_mode, st, sp, cnd} = '0;
      {paddr, fdr, pwdata, ev, tn} = '0;
      pos = 2'd1;
      {error_cnt, comparisons, run, spin} = '0;
      void'($urandom(32'hb412));
      sel = $urandom_range(7);
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      apb(0, `FSH_A_CTRL, 0); chk(rd, `FSH_CTRL_RST);
      apb(0, 8'h0c, 0); chk({er, rd[30:0]}, 32'h8000_0000);
      apb(1, `FSH_A_CTRL, 32'h7 | (sel << 4));
      apb(0, `FSH_A_CTRL, 0); chk(rd, 32'h7 | (sel << 4));
      sp <= 1'b1; settle(DEB + 6);
      mode_auto <= 1'b1; settle(3);
      apb(0, `FSH_A_STAT, 0); chk({rd[9], rd[2:0]}, 32'hd);
      sp <= 1'b0; settle(DEB + 6);
      apb(1, `FSH_A_STAT, 1 << 9); apb(0, `FSH_A_STAT, 0); chk(rd[2:0], 0);
      setpos(3); pulse(3); settle(2); cmp();
      setpos(1); cmp(); pulse(3); spin = 1; settle(2); cmp();
      pulse(0); run = 1; settle(2); cmp();
      foreach (sel_tab[i]) begin setpos(sel_tab[i]); cmp(); end
      pulse(1); run = 0; settle(2); cmp(); pulse(0); run = 1; settle(2); cmp();
      sp <= 1'b1; run = 0; settle(DEB + 6); cmp(); sp <= 1'b0;
      st <= 1'b1; run = 1; settle(DEB + 6); cmp(); st <= 1'b0; settle(DEB + 6);
      pulse(5); run = 0; settle(2); cmp(); chk(cst, 1);
      pulse(0); run = 1; settle(2); cmp(); chk(cst, 0);
      single_mode <= 1'b1; pulse(8); run = 0; settle(2); cmp();
      cnd <= 1'b1; pulse(0); run = 1; settle(2); cmp(); pulse(11); run = 0; settle(2); cmp();
      setpos(3); pulse(0); run = 1; settle(2); cmp(); setpos(1); cmp();
      single_mode <= 1'b0; cnd <= 1'b0; pulse(0); run = 1; settle(2); cmp();
      fdr[sel] <= 1'b1; settle(DEB + 6); pulse(5); run = 0; settle(2); cmp();
      apb(0, `FSH_A_STAT, 0); chk({rd[10], rd[2:0]}, 32'hd);
      apb(1, `FSH_A_STAT, 1 << 10); pulse(0); run = 1; pulse(6); run = 0; settle(2);
      apb(0, `FSH_A_STAT, 0); chk({rd[10], rd[2:0]}, 0);
      fdr <= '0; pulse(0); run = 1; setpos(2); pulse(2); #1;
      chk(disc, 1); run = 0; spin = 0; settle(1); cmp(); setpos(1); cmp();
      v = 16'($urandom); v2 = ~v; tn <= 4'h3;
      apb(1, `FSH_A_OFS, {v, 16'h3}); pulse(7); apb(0, `FSH_A_OFS, 0); chk(rd[31:16], v);
      chk(act, {16'h0, v});
      apb(1, `FSH_A_OFS, {v2, 16'h3}); apb(0, `FSH_A_OFS, 0); chk(rd[31:16], v);
      pulse(6); settle(2); apb(0, `FSH_A_OFS, 0); chk(rd[31:16], v2);
      chk(act, {16'h0, v2});
      results();
   end

   initial begin
      repeat (4000) @(posedge clk);
      error_cnt++;
      results();
   end
endmodule : tb_top
`default_nettype wire
